// ===== rtl/pviu_regs.vh
`ifndef PVIU_REGS_VH
`define PVIU_REGS_VH

// Source count and vector numbering (vector 1 is index 0)
`define PVIU_NSRC          11
`define PVIU_NIDX_W        4
// Source indices
`define PVIU_SRC_BUS       0
`define PVIU_SRC_T128      1
`define PVIU_SRC_T1024     2
`define PVIU_SRC_EP0       3
`define PVIU_SRC_EP1       4
`define PVIU_SRC_EP2       5
`define PVIU_SRC_SPI       6
`define PVIU_SRC_CAPA      7
`define PVIU_SRC_CAPB      8
`define PVIU_SRC_GPIO      9
`define PVIU_SRC_WAKE      10
// Vector table
`define PVIU_RESET_VEC     13'h0000
`define PVIU_VEC_BASE      13'h0002
`define PVIU_VEC_STRIDE    13'h0002
`define PVIU_ADDR_W        13
// Status register bit positions
`define PVIU_PSC_IRQ_PEND  7
`define PVIU_PSC_GIE       2
// Reset values
`define PVIU_ENA_RST       11'h000
`define PVIU_PEND_RST      11'h000
`define PVIU_GIE_RST       1'b0

`endif

// ===== rtl/pviu_vec_rom.v
`timescale 1ns/1ps
// Vector address table, registered read
module pviu_vec_rom (
    ref_clk,
    rst_q_b,
    rd_en,
    rd_idx,
    rd_addr
);
`include "pviu_regs.vh"
    input  wire                      ref_clk;
    input  wire                      rst_q_b;
    input  wire                      rd_en;
    input  wire [`PVIU_NIDX_W-1:0]   rd_idx;
    output reg  [`PVIU_ADDR_W-1:0]   rd_addr;

    always @(posedge ref_clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            rd_addr <= `PVIU_RESET_VEC;
        end else if (rd_en) begin
            case (rd_idx)
                4'h0:    rd_addr <= 13'h0002;
                4'h1:    rd_addr <= 13'h0004;
                4'h2:    rd_addr <= 13'h0006;
                4'h3:    rd_addr <= 13'h0008;
                4'h4:    rd_addr <= 13'h000a;
                4'h5:    rd_addr <= 13'h000c;
                4'h6:    rd_addr <= 13'h000e;
                4'h7:    rd_addr <= 13'h0010;
                4'h8:    rd_addr <= 13'h0012;
                4'h9:    rd_addr <= 13'h0014;
                4'ha:    rd_addr <= 13'h0016;
                default: rd_addr <= `PVIU_RESET_VEC;
            endcase
        end
    end

endmodule

// ===== rtl/pviu_ctrl.v
`timescale 1ns/1ps
// Notes on behaviour
// R1: All listed sources interrupt, each maskable.
// R2: Enable bit one enables its source.
// R3: Reset clears enables and global enable.
// R4: One pending flop per source, set on event.
// R5: Pending cleared only by service or reset.
// R6: Request needs pending and its enable.
// R7: Highest request serviced at instruction boundary.
// R8: Clear global, clear pending, then call.
// R9: Global enable visible at status bit 2.
// R10: Call pushes PC, carry and zero.
// R11: Return restores PC, flags; sets global enable.
// R12: Mask/unmask ops touch only global enable.
// R13: Nesting allowed; depth bounded by stack.
// R14: Status bit 7 reports any enabled pending while global enable is clear.
// R15: Fixed priority, vector 1 highest, 11 lowest.
// R16: Fetch starts at address zero after reset.
// R17: Each vector entry is two bytes.
// R18: Vectors 1..8 at 0x0002 through 0x0010.
// R19: Capture rise/fall events share one request.
// R20: Vectors 9..11 continue table, wake-up last.
// R21: Only the single highest request acknowledged.
module pviu_ctrl (
    ref_clk,
    rst_b,
    bus_evt,
    t128_evt,
    t1024_evt,
    ep_evt,
    spi_evt,
    capa_rise_evt,
    capa_fall_evt,
    capb_rise_evt,
    capb_fall_evt,
    gpio_evt,
    wake_evt,
    glob_ena_wr,
    glob_ena_wdata,
    ep_ena_wr,
    ep_ena_wdata,
    instr_done,
    mask_all_op,
    unmask_all_op,
    return_from_handler,
    pc_in,
    carry_flag,
    zero_flag,
    pop_data,
    ack_pulse,
    ack_addr,
    push_valid,
    push_data,
    restore_valid,
    restore_pc,
    restore_carry,
    restore_zero,
    glob_ena_q,
    ep_ena_q,
    pend_q,
    psc_status,
    fetch_addr
);
`include "pviu_regs.vh"
    input  wire                      ref_clk;
    input  wire                      rst_b;
    input  wire                      bus_evt;
    input  wire                      t128_evt;
    input  wire                      t1024_evt;
    input  wire [2:0]                ep_evt;
    input  wire                      spi_evt;
    input  wire                      capa_rise_evt;
    input  wire                      capa_fall_evt;
    input  wire                      capb_rise_evt;
    input  wire                      capb_fall_evt;
    input  wire                      gpio_evt;
    input  wire                      wake_evt;
    input  wire                      glob_ena_wr;
    input  wire [7:0]                glob_ena_wdata;
    input  wire                      ep_ena_wr;
    input  wire [2:0]                ep_ena_wdata;
    input  wire                      instr_done;
    input  wire                      mask_all_op;
    input  wire                      unmask_all_op;
    input  wire                      return_from_handler;
    input  wire [`PVIU_ADDR_W-1:0]   pc_in;
    input  wire                      carry_flag;
    input  wire                      zero_flag;
    input  wire [`PVIU_ADDR_W+1:0]   pop_data;
    output reg                       ack_pulse;
    output wire [`PVIU_ADDR_W-1:0]   ack_addr;
    output reg                       push_valid;
    output reg  [`PVIU_ADDR_W+1:0]   push_data;
    output reg                       restore_valid;
    output reg  [`PVIU_ADDR_W-1:0]   restore_pc;
    output reg                       restore_carry;
    output reg                       restore_zero;
    output reg                       glob_ena_q;
    output reg  [2:0]                ep_ena_q;
    output reg  [`PVIU_NSRC-1:0]     pend_q;
    output wire [7:0]                psc_status;
    output reg  [`PVIU_ADDR_W-1:0]   fetch_addr;

    reg                              rst_s1_q;
    reg                              rst_q;
    reg  [6:0]                       gena_q;
    reg                              fetch_vld_q;
    reg  [`PVIU_NSRC-1:0]            evt_vec;
    reg  [`PVIU_NSRC-1:0]            ena_vec;
    wire [`PVIU_NSRC-1:0]            req_vec;
    wire [`PVIU_NSRC-1:0]            grant;
    wire [`PVIU_NIDX_W-1:0]          grant_idx;
    wire                             take;
    reg  [7:0]                       psc_comb;

    // Lowest index wins: vector 1 highest
    function [`PVIU_NSRC-1:0] pick_first;
        input [`PVIU_NSRC-1:0] r;
        integer i;
        reg     found;
        begin
            pick_first = {`PVIU_NSRC{1'b0}};
            found = 1'b0;
            for (i = 0; i < `PVIU_NSRC; i = i + 1) begin
                if (r[i] && !found) begin
                    pick_first[i] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Index of a one-hot grant; zero when idle
    function [`PVIU_NIDX_W-1:0] onehot_idx;
        input [`PVIU_NSRC-1:0] g;
        integer i;
        begin
            onehot_idx = {`PVIU_NIDX_W{1'b0}};
            for (i = 0; i < `PVIU_NSRC; i = i + 1) begin
                if (g[i]) begin
                    onehot_idx = i[`PVIU_NIDX_W-1:0];
                end
            end
        end
    endfunction

    // Reset release through two flops
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_q    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q    <= rst_s1_q;
        end
    end

    // One event line per pending flop
    always @* begin
        evt_vec                     = {`PVIU_NSRC{1'b0}};
        evt_vec[`PVIU_SRC_BUS]      = bus_evt; // R1
        evt_vec[`PVIU_SRC_T128]     = t128_evt; // R1
        evt_vec[`PVIU_SRC_T1024]    = t1024_evt; // R1
        evt_vec[`PVIU_SRC_EP0]      = ep_evt[0]; // R1
        evt_vec[`PVIU_SRC_EP1]      = ep_evt[1]; // R1
        evt_vec[`PVIU_SRC_EP2]      = ep_evt[2]; // R1
        evt_vec[`PVIU_SRC_SPI]      = spi_evt; // R1
        evt_vec[`PVIU_SRC_CAPA]     = capa_rise_evt | capa_fall_evt; // R19
        evt_vec[`PVIU_SRC_CAPB]     = capb_rise_evt | capb_fall_evt; // R19
        evt_vec[`PVIU_SRC_GPIO]     = gpio_evt; // R1
        evt_vec[`PVIU_SRC_WAKE]     = wake_evt; // R1
    end

    // Global register bits: bus,t128,t1024,spi,capture(A+B),gpio,wake
    always @* begin
        ena_vec                     = {`PVIU_NSRC{1'b0}};
        ena_vec[`PVIU_SRC_BUS]      = gena_q[0];
        ena_vec[`PVIU_SRC_T128]     = gena_q[1];
        ena_vec[`PVIU_SRC_T1024]    = gena_q[2];
        ena_vec[`PVIU_SRC_EP0]      = ep_ena_q[0];
        ena_vec[`PVIU_SRC_EP1]      = ep_ena_q[1];
        ena_vec[`PVIU_SRC_EP2]      = ep_ena_q[2];
        ena_vec[`PVIU_SRC_SPI]      = gena_q[3];
        ena_vec[`PVIU_SRC_CAPA]     = gena_q[4];
        ena_vec[`PVIU_SRC_CAPB]     = gena_q[4];
        ena_vec[`PVIU_SRC_GPIO]     = gena_q[5];
        ena_vec[`PVIU_SRC_WAKE]     = gena_q[6];
    end

    assign req_vec   = pend_q & ena_vec; // R6
    // Global gate applies only at an instruction boundary
    assign take      = instr_done && glob_ena_q && (|req_vec); // R7
    assign grant     = take ? pick_first(req_vec) : {`PVIU_NSRC{1'b0}}; // R15 R21
    assign grant_idx = onehot_idx(grant);

    // Enable registers
    always @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            gena_q   <= 7'h00; // R3
            ep_ena_q <= 3'h0; // R3
        end else begin
            if (glob_ena_wr) begin
                // Bit 7 of the write is spare
                gena_q <= glob_ena_wdata[6:0]; // R2
            end
            if (ep_ena_wr) begin
                ep_ena_q <= ep_ena_wdata; // R2
            end
        end
    end

    // Pending flops; a new event in the grant cycle wins
    always @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            pend_q <= `PVIU_PEND_RST;
        end else begin
            pend_q <= (pend_q & ~grant) | evt_vec; // R4 R5 R8
        end
    end

    // Global enable
    // Service outranks mask and unmask so a handler starts masked
    always @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            glob_ena_q <= `PVIU_GIE_RST; // R3
        end else if (take) begin
            glob_ena_q <= 1'b0; // R8
        end else if (mask_all_op) begin
            glob_ena_q <= 1'b0; // R12
        end else if (unmask_all_op || return_from_handler) begin
            glob_ena_q <= 1'b1; // R11 R12 R13
        end
    end

    // Vector lookup, registered
    pviu_vec_rom u_vec_rom (
        .ref_clk (ref_clk),
        .rst_q_b (rst_q),
        .rd_en   (take),
        .rd_idx  (grant_idx),
        .rd_addr (ack_addr)
    ); // R17 R18 R20

    // Call sequencing: push and ack one cycle after grant, fetch redirect one cycle later
    always @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            ack_pulse  <= 1'b0;
            push_valid <= 1'b0;
            push_data  <= {(`PVIU_ADDR_W+2){1'b0}};
        end else begin
            ack_pulse  <= take; // R8
            push_valid <= take; // R10
            if (take) begin
                push_data <= {carry_flag, zero_flag, pc_in}; // R10
            end
        end
    end

    // Restore path from stack on return
    always @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            restore_valid <= 1'b0;
            restore_pc    <= {`PVIU_ADDR_W{1'b0}};
            restore_carry <= 1'b0;
            restore_zero  <= 1'b0;
        end else begin
            restore_valid <= return_from_handler; // R11
            if (return_from_handler) begin
                restore_pc    <= pop_data[`PVIU_ADDR_W-1:0]; // R11
                restore_carry <= pop_data[`PVIU_ADDR_W+1];
                restore_zero  <= pop_data[`PVIU_ADDR_W];
            end
        end
    end

    // Fetch start after reset
    // Vector address lands in fetch_addr one cycle after ack_pulse, two after grant
    always @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            fetch_addr  <= `PVIU_RESET_VEC; // R16
            fetch_vld_q <= 1'b0;
        end else begin
            fetch_vld_q <= 1'b1;
            if (!fetch_vld_q) begin
                fetch_addr <= `PVIU_RESET_VEC; // R16
            end else if (ack_pulse) begin
                fetch_addr <= ack_addr;
            end
        end
    end

    // Status byte; bits owned by other blocks read zero here
    always @* begin
        psc_comb                     = 8'h00;
        psc_comb[`PVIU_PSC_IRQ_PEND] = (|req_vec) & ~glob_ena_q; // R14
        psc_comb[`PVIU_PSC_GIE]      = glob_ena_q; // R9
    end

    assign psc_status = psc_comb;

endmodule

// ===== verif/pviu_asserts.sv
`timescale 1ns/1ps
`include "pviu_regs.vh"
module pviu_asserts (
    input logic        ref_clk,
    input logic        rst_b,
    input logic        instr_done,
    input logic        mask_all_op,
    input logic        return_from_handler,
    input logic        ack_pulse,
    input logic [12:0] ack_addr,
    input logic        push_valid,
    input logic [14:0] push_data,
    input logic        carry_flag,
    input logic        zero_flag,
    input logic [12:0] pc_in,
    input logic        restore_valid,
    input logic        glob_ena_q,
    input logic [10:0] pend_q,
    input logic [7:0]  psc_status,
    input logic [12:0] fetch_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_ack_cause: assert property (ack_pulse |-> $past(instr_done) && $past(glob_ena_q))
        else $error("ack without boundary");
    a_ack_gie: assert property (ack_pulse |-> !glob_ena_q)
        else $error("global enable kept");
    a_push_ack: assert property (ack_pulse |-> push_valid
        && push_data == {$past(carry_flag), $past(zero_flag), $past(pc_in)})
        else $error("no push");
    a_fetch_vec: assert property (ack_pulse |=> fetch_addr == ack_addr)
        else $error("bad fetch");
    a_vec_even: assert property (ack_pulse |-> !ack_addr[0] && ack_addr inside {[2:22]})
        else $error("bad vector");
    a_pend_hold: assert property (|($past(pend_q) & ~pend_q) |-> ack_pulse)
        else $error("pending lost");
    a_mask_keeps: assert property (mask_all_op && !instr_done
        |=> !glob_ena_q && ($past(pend_q) & ~pend_q) == 11'h000)
        else $error("mask side effect");
    a_return_gie: assert property (return_from_handler && !mask_all_op && !instr_done
        |=> restore_valid && glob_ena_q)
        else $error("return failed");
    a_status_bits: assert property (psc_status[6:0] == {4'h0, glob_ena_q, 2'h0})
        else $error("bad status");
endmodule
bind pviu_ctrl pviu_asserts chk (.ref_clk, .rst_b, .instr_done, .mask_all_op,
    .return_from_handler, .ack_pulse, .ack_addr, .push_valid, .restore_valid,
    .push_data, .carry_flag, .zero_flag, .pc_in,
    .glob_ena_q, .pend_q, .psc_status, .fetch_addr);

// ===== verif/pviu_stack_model.sv
`timescale 1ns/1ps
module pviu_stack_model (
    input  logic        ref_clk,
    input  logic        push_valid,
    input  logic [14:0] push_data,
    input  logic        pop_req,
    output logic [14:0] pop_data
);
    logic [14:0] stk[$];
    logic [14:0] last_q = 15'h0000;
    // Depth limited only by memory
    always @(posedge ref_clk) begin
        if (push_valid) stk.push_back(push_data);
        if (pop_req && stk.size() > 0) last_q = stk.pop_back();
        // Empty stack shows inverted stale data
        pop_data <= (stk.size() > 0) ? stk[$] : ~last_q;
    end
endmodule

// ===== verif/tb_prioritized_vectored_interrupt_unit.sv
`timescale 1ns/1ps
`include "pviu_regs.vh"
module tb_prioritized_vectored_interrupt_unit;
    logic        ref_clk, rst_b, carry_flag, zero_flag, cap_sel, glob_ena_q, ack_pulse;
    logic        push_valid, restore_valid, restore_carry, restore_zero;
    logic [10:0] ev, pend_q;
    logic [5:0]  ctl;
    logic [7:0]  glob_ena_wdata, psc_status;
    logic [2:0]  ep_ena_wdata, ep_ena_q;
    logic [12:0] pc_in, ack_addr, restore_pc, fetch_addr;
    logic [14:0] pop_data, push_data;
    int          fails = 0, compares = 0, cyc = 0, pm = 0, em = 0, gie = 0;
    int          ps[$];
    pviu_ctrl dut (.ref_clk, .rst_b, .bus_evt(ev[0]), .t128_evt(ev[1]), .t1024_evt(ev[2]),
        .ep_evt(ev[5:3]), .spi_evt(ev[6]), .capa_rise_evt(ev[7] & cap_sel),
        .capa_fall_evt(ev[7] & ~cap_sel), .capb_rise_evt(ev[8] & cap_sel),
        .capb_fall_evt(ev[8] & ~cap_sel), .gpio_evt(ev[9]), .wake_evt(ev[10]),
        .glob_ena_wr(ctl[4]), .glob_ena_wdata, .ep_ena_wr(ctl[5]), .ep_ena_wdata,
        .instr_done(ctl[0]), .mask_all_op(ctl[1]), .unmask_all_op(ctl[2]),
        .return_from_handler(ctl[3]), .pc_in, .carry_flag, .zero_flag, .pop_data,
        .ack_pulse, .ack_addr, .push_valid, .push_data, .restore_valid, .restore_pc,
        .restore_carry, .restore_zero, .glob_ena_q, .ep_ena_q, .pend_q, .psc_status,
        .fetch_addr);
    pviu_stack_model stack (.ref_clk, .push_valid, .push_data, .pop_req(ctl[3]), .pop_data);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            print_verdict;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic [5:0] v);
        @(posedge ref_clk) ctl <= v;
        @(posedge ref_clk) ctl <= 6'h00;
        #1;
    endtask
    task automatic state;
        chk(pend_q, pm);
        chk(glob_ena_q, gie);
        chk(psc_status, {(gie == 0 && (pm & em) != 0), 4'h0, gie[0], 2'h0});
    endtask
    task automatic en(input int b);
        op(b ? 6'h04 : 6'h02);
        gie = b;
        state;
    endtask
    task automatic evt(input logic [10:0] m);
        @(posedge ref_clk) ev <= m;
        cap_sel <= 1'($urandom);
        @(posedge ref_clk) ev <= 11'h000;
        #1;
        pm |= m;
        state;
    endtask
    task automatic wr(input logic [10:0] v);
        {glob_ena_wdata, ep_ena_wdata} <= v;
        op(6'h30);
        em = {v[9], v[8], v[7], v[7], v[6], v[2:0], v[5:3]};
        chk(ep_ena_q, v[2:0]);
        state;
    endtask
    task automatic grant;
        int i;
        int r;
        i = 0;
        r = pm & em;
        {carry_flag, zero_flag, pc_in} <= 15'($urandom);
        op(6'h01);
        chk(ack_pulse, gie != 0 && r != 0);
        if (gie != 0 && r != 0) begin
            while (!r[i]) i++;
            chk(ack_addr, 2 + 2 * i);
            chk(push_data, {carry_flag, zero_flag, pc_in});
            ps.push_back({carry_flag, zero_flag, pc_in});
            pm[i] = 0;
            gie = 0;
        end
        state;
    endtask
    task automatic ret;
        int v;
        v = ps.pop_back();
        op(6'h08);
        gie = 1;
        chk({restore_carry, restore_zero, restore_pc}, v);
        state;
    endtask
    initial begin
        {rst_b, ctl, ev, cap_sel, pc_in, carry_flag, zero_flag} = 0;
        {glob_ena_wdata, ep_ena_wdata} = 0;
        void'($urandom(51937));
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(fetch_addr, 0);
        chk(ep_ena_q, 0);
        state;
        $display("test reset done");
        evt(11'h7ff);
        grant;
        en(1);
        grant;
        en(0);
        wr(11'h7ff);
        en(1);
        $display("test masking done");
        repeat (11) begin
            grant;
            en(1);
        end
        while (ps.size() > 0) ret;
        $display("test priority done");
        repeat (200) begin
            case ($urandom % 5)
                0: evt(11'($urandom));
                1: wr(11'($urandom));
                2: grant;
                3: if (ps.size() > 0) ret; else en(1);
                default: en(0);
            endcase
        end
        $display("test random done");
        print_verdict;
    end
endmodule
